//--- rtl/expbus_pkg.sv
// constants shared by the expansion bus and chip select design
package expbus_pkg;

	// ==========================================
	// register byte offsets on the control bus
	localparam logic [7:0] OFF_BUS_CONTROL = 8'h00;
	localparam logic [7:0] OFF_CLEAR_INT   = 8'h04;
	localparam logic [7:0] OFF_MASK_OPTION = 8'h08;
	localparam logic [7:0] OFF_STATUS      = 8'h0C;

	// ==========================================
	// bus control field positions and reset value
	localparam int BCR_LOW_ADDR_EN  = 0;
	localparam int BCR_HIGH_ADDR_EN = 1;
	localparam int BCR_SPEED_SEL2   = 2;
	localparam int BCR_SPEED_SEL1   = 3;
	localparam int BCR_WIDTH        = 4;
	localparam logic [3:0] BCR_RESET = 4'h0;
	localparam int CIR_SPEED_SEL3   = 2;
	localparam logic CIR_SPEED_RESET = 1'b0;

	// ==========================================
	// mask option status field positions
	localparam int MOR_TOP_ADDR = 5;
	localparam int MOR_SEL_EN   = 4;
	localparam int MOR_SEL1_24K = 3;
	localparam int MOR_CLK_DIV1 = 1;

	// ==========================================
	// select region map
	localparam logic [15:0] SEL4_BASE      = 16'h0800;
	localparam logic [15:0] SEL4_UPPER     = 16'h0C00;
	localparam logic [15:0] SEL1_BASE      = 16'h1000;
	localparam logic [15:0] SEL2_BASE_24K  = 16'h7000;
	localparam logic [15:0] SEL2_BASE_32K  = 16'h9000;
	localparam logic [15:0] SEL3_BASE_24K  = 16'h9000;
	localparam logic [15:0] SEL3_BASE_32K  = 16'hB000;
	localparam logic [15:0] SEL3_LIMIT     = 16'hC000;

	// ==========================================
	// cycles per bus phase, full and half speed
	localparam logic [1:0] PHASE_NORMAL   = 2'h1;
	localparam logic [1:0] PHASE_EXTENDED = 2'h2;

	// ==========================================
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- rtl/ext_region_decode.sv
// address decoder for the four external select regions
`timescale 1ns/1ps
module ext_region_decode
	import expbus_pkg::*;
(
	input  wire logic [15:0] addr,
	input  wire logic        sel1Is24k,
	output logic      [3:0]  sel,
	output logic             sel4Upper
);
	logic [15:0] sel2Base;
	logic [15:0] sel3Base;

	// =========================================
	// region bounds follow the first region size
	always_comb begin
		sel2Base  = sel1Is24k ? SEL2_BASE_24K : SEL2_BASE_32K;
		sel3Base  = sel1Is24k ? SEL3_BASE_24K : SEL3_BASE_32K;
		sel[0]    = (addr >= SEL1_BASE) && (addr < sel2Base);
		sel[1]    = (addr >= sel2Base) && (addr < sel3Base);
		sel[2]    = (addr >= sel3Base) && (addr < SEL3_LIMIT);
		sel[3]    = (addr >= SEL4_BASE) && (addr < SEL1_BASE);
		sel4Upper = (addr >= SEL4_UPPER);
	end
endmodule // ext_region_decode

//--- rtl/pin_driver.sv
// registered output pin group with an output enable
`timescale 1ns/1ps
module pin_driver #(
	parameter int W = 8
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] valIn,
	input  wire logic         oeIn,
	output logic      [W-1:0] pinOut,
	output logic      [W-1:0] pinOe
);
	typedef struct packed {
		logic [W-1:0] val;
		logic         oe;
	} pin_t;

	pin_t s;
	pin_t n;

	// =========================================
	// next value
	always_comb begin
		n.val = valIn;
		n.oe  = oeIn;
	end

	// =========================================
	// reset floats the pins
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end

	assign pinOut = s.val;
	assign pinOe  = {W{s.oe}};
endmodule // pin_driver

//--- rtl/expansion_bus_chip_select.sv
// expansion bus sequencer, select outputs and control registers
`timescale 1ns/1ps

module expansion_bus_chip_select
	import expbus_pkg::*;
#(
	parameter logic TOP_ADDR_OPT = 1'b1,
	parameter logic SEL_OPT      = 1'b1,
	parameter logic SEL1_24K_OPT = 1'b0,
	parameter logic CLK_DIV1_OPT = 1'b1
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic      [1:0]  s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	input  wire logic        cpuReq,
	input  wire logic [15:0] cpuAddr,
	input  wire logic        cpuWrite,
	input  wire logic [7:0]  cpuWdata,
	output logic      [7:0]  cpuRdata,
	output logic             cpuDone,
	output logic             cpuBusy,
	input  wire logic [7:0]  muxedAddrDataBusIn,
	output logic      [7:0]  muxedAddrDataBusOut,
	output logic      [7:0]  muxedAddrDataBusOe,
	output logic             readStrobeOut_n,
	output logic             writeStrobeOut_n,
	output logic             addrLatchStrobe_n,
	input  wire logic [7:0]  portFGpData,
	output logic      [7:0]  portFPinsOut,
	output logic      [7:0]  portFPinsOe,
	input  wire logic [3:0]  portELowGpData,
	output logic      [3:0]  portELowPinsOut,
	output logic      [3:0]  portELowPinsOe
);
	import expbus_pkg::*;

	typedef enum logic [1:0] {IDLE, ADDR, DATA} phase_t;

	typedef struct packed {
		phase_t      phase;
		logic [1:0]  cnt;
		logic        slow;
		logic [3:0]  sel;
		logic [15:0] addr;
		logic        write;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
		logic        done;
		logic        busy;
		logic        rdN;
		logic        wtN;
		logic        aleN;
		logic [3:0]  bus_control_reg;
		logic        cirSpeed;
		logic        awRdy;
		logic        awHave;
		logic [7:0]  awAddr;
		logic        wRdy;
		logic        wHave;
		logic [7:0]  wData;
		logic        wLane;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arRdy;
		logic        rvalid;
		logic [31:0] rData;
		logic [1:0]  rresp;
	} state_t;

	state_t      s;
	state_t      n;
	logic [3:0]  decSel;
	logic        decUpper;
	logic        reqSlow;
	logic [1:0]  phaseLen;
	logic [7:0]  maskValue;
	logic [7:0]  rdAddr;
	logic [7:0]  busVal;
	logic        busOe;
	logic [7:0]  pfVal;
	logic [3:0]  peVal;
	logic        inCycle;

	// =========================================
	// region decode of the incoming request
	ext_region_decode u_decode (
		.addr      (cpuAddr),
		.sel1Is24k (SEL1_24K_OPT),
		.sel       (decSel),
		.sel4Upper (decUpper)
	);

	// =========================================
	// per-region speed; a zero bit means half speed
	always_comb begin
		if (decSel[0]) begin
			reqSlow = !s.bus_control_reg[BCR_SPEED_SEL1];
		end else if (decSel[1]) begin
			reqSlow = !s.bus_control_reg[BCR_SPEED_SEL2];
		end else if (decSel[2] || (decSel[3] && decUpper)) begin
			reqSlow = !s.cirSpeed;
		end else begin
			reqSlow = 1'b0;
		end
	end

	// fixed option report, unused bits tied low
	always_comb begin
		maskValue               = 8'h00;
		maskValue[MOR_TOP_ADDR] = TOP_ADDR_OPT;
		maskValue[MOR_SEL_EN]   = SEL_OPT;
		maskValue[MOR_SEL1_24K] = SEL1_24K_OPT;
		maskValue[MOR_CLK_DIV1] = CLK_DIV1_OPT;
	end

	assign phaseLen = s.slow ? PHASE_EXTENDED : PHASE_NORMAL;
	assign rdAddr   = {s_axi_araddr[7:2], 2'b00};

	// =========================================
	// bus sequencer and register slave, next state
	always_comb begin
		n      = s;
		n.done = 1'b0;
		unique case (s.phase)
			IDLE: begin
				if (cpuReq) begin
					n.phase = ADDR;
					n.cnt   = 2'h0;
					n.addr  = cpuAddr;
					n.write = cpuWrite;
					n.wdata = cpuWdata;
					n.sel   = decSel;
					n.slow  = reqSlow;
					n.busy  = 1'b1;
				end
			end
			ADDR: begin
				if (s.cnt == phaseLen - 2'h1) begin
					n.phase = DATA;
					n.cnt   = 2'h0;
				end else begin
					n.cnt = s.cnt + 2'h1;
				end
			end
			DATA: begin
				if (s.cnt == phaseLen - 2'h1) begin
					n.phase = IDLE;
					n.cnt   = 2'h0;
					n.done  = 1'b1;
					n.busy  = 1'b0;
					if (!s.write) begin
						n.rdata = muxedAddrDataBusIn;
					end
				end else begin
					n.cnt = s.cnt + 2'h1;
				end
			end
			// the spare code of the two-bit phase falls back to idle
			default: begin
				n.phase = IDLE;
				n.cnt   = 2'h0;
				n.busy  = 1'b0;
			end
		endcase

		// strobes follow the phase being entered
		n.aleN = !(n.phase == ADDR);
		n.rdN  = !(n.phase == DATA && !n.write);
		n.wtN  = !(n.phase == DATA && n.write);

		// write address and data taken in either order
		if (s_axi_awvalid && s.awRdy) begin
			n.awHave = 1'b1;
			n.awAddr = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s.wRdy) begin
			n.wHave = 1'b1;
			n.wData = s_axi_wdata[7:0];
			n.wLane = s_axi_wstrb[0];
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (n.awHave && n.wHave && !n.bvalid) begin
			n.awHave = 1'b0;
			n.wHave  = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = RESP_OKAY;
			if (n.awAddr == OFF_BUS_CONTROL) begin
				if (n.wLane) begin
					n.bus_control_reg = n.wData[BCR_WIDTH-1:0];
				end
			end else if (n.awAddr == OFF_CLEAR_INT) begin
				if (n.wLane) begin
					n.cirSpeed = n.wData[CIR_SPEED_SEL3];
				end
			end else begin
				n.bresp = RESP_SLVERR;
			end
		end
		n.awRdy = !n.awHave && !n.bvalid;
		n.wRdy  = !n.wHave && !n.bvalid;

		// read answer is one cycle after the address
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arRdy) begin
			n.rvalid = 1'b1;
			n.rresp  = RESP_OKAY;
			n.rData  = 32'h0000_0000;
			unique case (rdAddr)
				OFF_BUS_CONTROL: n.rData[BCR_WIDTH-1:0] = s.bus_control_reg;
				OFF_CLEAR_INT:   n.rData[CIR_SPEED_SEL3] = s.cirSpeed;
				OFF_MASK_OPTION: n.rData[7:0] = maskValue;
				OFF_STATUS:      n.rData[7:0] = {2'b00, s.sel, s.slow, s.busy};
				default:         n.rresp = RESP_SLVERR;
			endcase
		end
		n.arRdy = !n.rvalid;
	end

	// =========================================
	// pin values, registered in the pin drivers
	always_comb begin
		inCycle = (n.phase != IDLE);
		busOe   = !(n.phase == DATA && !n.write);
		if (n.phase == DATA) begin
			busVal = n.wdata;
		end else begin
			busVal = n.addr[11:4];
		end
		pfVal = portFGpData;
		if (s.bus_control_reg[BCR_LOW_ADDR_EN]) begin
			pfVal[3:0] = n.addr[3:0];
		end
		if (s.bus_control_reg[BCR_HIGH_ADDR_EN]) begin
			pfVal[6:4] = n.addr[14:12];
		end
		if (TOP_ADDR_OPT) begin
			pfVal[7] = n.addr[15];
		end
		if (SEL_OPT) begin
			peVal = ~(n.sel & {4{inCycle}});
		end else begin
			peVal = portELowGpData;
		end
	end

	// the bus is released only in reset and while an outside part answers a read
	pin_driver #(.W(8)) u_busPins (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ce      (ce),
		.valIn   (busVal),
		.oeIn    (busOe),
		.pinOut  (muxedAddrDataBusOut),
		.pinOe   (muxedAddrDataBusOe)
	);

	pin_driver #(.W(8)) u_portFPins (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ce      (ce),
		.valIn   (pfVal),
		.oeIn    (1'b1),
		.pinOut  (portFPinsOut),
		.pinOe   (portFPinsOe)
	);

	pin_driver #(.W(4)) u_portEPins (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ce      (ce),
		.valIn   (peVal),
		.oeIn    (1'b1),
		.pinOut  (portELowPinsOut),
		.pinOe   (portELowPinsOe)
	);

	// =========================================
	// state register; reset wins over the clock enable
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s          <= '0;
			s.phase    <= IDLE;
			s.rdN      <= 1'b1;
			s.wtN      <= 1'b1;
			s.aleN     <= 1'b1;
			s.bus_control_reg      <= BCR_RESET;
			s.cirSpeed <= CIR_SPEED_RESET;
		end else if (ce) begin
			s <= n;
		end
	end

	assign s_axi_awready    = s.awRdy;
	assign s_axi_wready     = s.wRdy;
	assign s_axi_bvalid     = s.bvalid;
	assign s_axi_bresp      = s.bresp;
	assign s_axi_arready    = s.arRdy;
	assign s_axi_rvalid     = s.rvalid;
	assign s_axi_rdata      = s.rData;
	assign s_axi_rresp      = s.rresp;
	assign cpuRdata         = s.rdata;
	assign cpuDone          = s.done;
	assign cpuBusy          = s.busy;
	assign readStrobeOut_n  = s.rdN;
	assign writeStrobeOut_n = s.wtN;
	assign addrLatchStrobe_n = s.aleN;

	// =========================================
	// checks
	sequence seqSlowAddr;
		!addrLatchStrobe_n ##1 addrLatchStrobe_n;
	endsequence

	sequence seqFallAle;
		$fell(addrLatchStrobe_n) && ce;
	endsequence

	a_reset_float: assert property (@(posedge clk_sys)
		!rst_n |=> muxedAddrDataBusOe == 8'h00 && portFPinsOe == 8'h00 && portELowPinsOe == 4'h0)
		else $error("pins not floating in reset");

	a_reset_strobes: assert property (@(posedge clk_sys)
		!rst_n |=> readStrobeOut_n && writeStrobeOut_n)
		else $error("strobes not high in reset");

	a_ale_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(addrLatchStrobe_n) |-> muxedAddrDataBusOe == 8'hFF && muxedAddrDataBusOut == s.addr[11:4])
		else $error("latch strobe without address on bus");

	a_pf_timing: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(addrLatchStrobe_n) && s.bus_control_reg[BCR_LOW_ADDR_EN] |-> portFPinsOut[3:0] == s.addr[3:0])
		else $error("port F low address out of step");

	a_slow_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
		seqFallAle ##0 s.slow ##1 ce |-> seqSlowAddr)
		else $error("half speed address phase not doubled");

	a_fast_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
		seqFallAle ##0 !s.slow |=> addrLatchStrobe_n)
		else $error("full speed address phase too long");

	a_speed_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(!rst_n) |-> s.bus_control_reg[BCR_SPEED_SEL1] == 1'b0 && s.bus_control_reg[BCR_SPEED_SEL2] == 1'b0 && !s.cirSpeed)
		else $error("speed controls not half after reset");

	a_sel4_speed: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(addrLatchStrobe_n) && s.sel[3] |-> s.slow == (s.addr >= SEL4_UPPER && !s.cirSpeed))
		else $error("fourth region speed wrong");

	a_mask_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && s_axi_arvalid && s_axi_arready && rdAddr == OFF_MASK_OPTION
		|=> s_axi_rdata == {24'h000000, maskValue} && maskValue[7:6] == 2'b00 && !maskValue[2] && !maskValue[0])
		else $error("mask option read wrong");

	a_mask_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(s_axi_bvalid) && s.awAddr == OFF_MASK_OPTION |-> s_axi_bresp == RESP_SLVERR && $stable(s.bus_control_reg))
		else $error("mask option write not refused");

	a_sel_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
		SEL_OPT && $fell(addrLatchStrobe_n) |-> portELowPinsOut == ~s.sel)
		else $error("select outputs wrong for address");

endmodule // expansion_bus_chip_select

//--- bench/ext_mem_model.sv
// external address latch and byte memory on the multiplexed expansion bus
`timescale 1ns/1ps
module ext_mem_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] busOut,
	input  wire logic       rdStrobe_n,
	input  wire logic       wrStrobe_n,
	input  wire logic       aleStrobe_n,
	output logic      [7:0] busIn
);
	logic [7:0] mem [256];
	logic [7:0] latchReg = 8'h00;
	logic [7:0] lastReg  = 8'h5A;

	// ==========================================
	// address latch, write capture, read answer
	always @(posedge clk_sys) begin
		if (!aleStrobe_n) latchReg <= busOut;
		if (!wrStrobe_n) mem[latchReg] <= busOut;
		if (!rdStrobe_n) lastReg <= mem[latchReg];
	end

	// a released bus shows the inverse of the last byte, never a held copy
	assign busIn = !rdStrobe_n ? mem[latchReg] : ~lastReg;
endmodule // ext_mem_model

//--- bench/test_expansion_bus_chip_select.sv
// self-checking bench for the expansion bus and select logic
`timescale 1ns/1ps
module test_expansion_bus_chip_select;
	import expbus_pkg::*;
	logic        clk_sys = 1'b0, rst_n = 1'b0;
	logic        awv = 1'b0, wv = 1'b0, bRdy = 1'b0, arv = 1'b0, rRdy = 1'b0;
	logic [7:0]  awAddr = 8'h00, arAddr = 8'h00, cpuWdata = 8'h00, gpF = 8'h00;
	logic [31:0] wData = 32'h0, rData, seed = 32'h4EE5665C, rnd;
	logic        awRdy, wRdy, bv, arRdy, rv, cpuDone, cpuBusy, rdN, wrN, aleN;
	logic [1:0]  bResp, rResp;
	logic        cpuReq = 1'b0, cpuWrite = 1'b0, cirBit = 1'b0;
	logic [15:0] cpuAddr = 16'h0;
	logic [3:0]  gpE = 4'h0, peOut, peOe, bcrVal = 4'h0;
	logic [7:0]  cpuRdata, busIn, busOut, busOe, pfOut, pfOe;
	logic [34:0] axiQ[$], axiE;
	logic [11:0] cpuQ[$], cpuE;
	int          failCount = 0, checkCount = 0, busyCnt = 0;
	// options at their defaults: top line, selects, 32K region, divide-by-1
	localparam logic [7:0] MASK_EXP = {2'b00, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
	localparam logic [15:0] ADDRS [6] = '{16'h2120, 16'h9560, 16'hB780, 16'h0C90, 16'h08A0, 16'hC000};
	localparam int RGS [6] = '{1, 2, 3, 4, 4, 0};

	always #50 clk_sys = ~clk_sys;

	expansion_bus_chip_select i_expansion_bus_chip_select (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
		.s_axi_awvalid(awv), .s_axi_awready(awRdy), .s_axi_awaddr(awAddr),
		.s_axi_wvalid(wv), .s_axi_wready(wRdy), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bv), .s_axi_bready(bRdy), .s_axi_bresp(bResp),
		.s_axi_arvalid(arv), .s_axi_arready(arRdy), .s_axi_araddr(arAddr),
		.s_axi_rvalid(rv), .s_axi_rready(rRdy), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.cpuReq(cpuReq), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .cpuWdata(cpuWdata),
		.cpuRdata(cpuRdata), .cpuDone(cpuDone), .cpuBusy(cpuBusy),
		.muxedAddrDataBusIn(busIn), .muxedAddrDataBusOut(busOut), .muxedAddrDataBusOe(busOe),
		.readStrobeOut_n(rdN), .writeStrobeOut_n(wrN), .addrLatchStrobe_n(aleN),
		.portFGpData(gpF), .portFPinsOut(pfOut), .portFPinsOe(pfOe),
		.portELowGpData(gpE), .portELowPinsOut(peOut), .portELowPinsOe(peOe)
	);

	ext_mem_model i_ext_mem_model (
		.clk_sys(clk_sys), .busOut(busOut), .rdStrobe_n(rdN),
		.wrStrobe_n(wrN), .aleStrobe_n(aleN), .busIn(busIn)
	);

	// ==========================================
	// helpers
	function automatic logic [31:0] nextRand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// port F: low and high address groups each fall back to the gp value
	function automatic logic [7:0] expPf(input logic [15:0] a);
		return {a[15], bcrVal[1] ? a[14:12] : gpF[6:4], bcrVal[0] ? a[3:0] : gpF[3:0]};
	endfunction

	function automatic logic fullSpd(input int rg, input logic [15:0] a);
		case (rg)
			1: return bcrVal[3];
			2: return bcrVal[2];
			3: return cirBit;
			4: return a[10] ? cirBit : 1'b1;
			default: return 1'b1;
		endcase
	endfunction

	task automatic check(input logic ok, input string msg);
		checkCount++;
		if (!ok) begin
			failCount++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic endSim();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic timeOut();
		failCount++;
		$display("[FAIL] %0t wait ran out", $time);
		endSim();
	endtask

	// ==========================================
	// register bus master, one transfer at a time
	task automatic axiWr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		int n;
		axiQ.push_back({1'b0, r, 32'h0});
		@(posedge clk_sys);
		awAddr <= a;
		wData <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bRdy <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			if (awv && awRdy === 1'b1) awv <= 1'b0;
			if (wv && wRdy === 1'b1) wv <= 1'b0;
			n++;
		end while (bv !== 1'b1 && n < 40);
		bRdy <= 1'b0;
		if (bv !== 1'b1) timeOut();
	endtask

	task automatic axiRd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		int n;
		axiQ.push_back({1'b1, r, 24'h0, d});
		@(posedge clk_sys);
		arAddr <= a;
		arv <= 1'b1;
		rRdy <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			if (arv && arRdy === 1'b1) arv <= 1'b0;
			n++;
		end while (rv !== 1'b1 && n < 40);
		rRdy <= 1'b0;
		if (rv !== 1'b1) timeOut();
	endtask

	// ==========================================
	// one external cycle; checks the address and data phases on the pins
	task automatic cpuCyc(input logic [15:0] a, input logic wr, input logic [7:0] d, input int rg);
		int n;
		logic full;
		full = fullSpd(rg, a);
		cpuQ.push_back({!wr, full ? 3'd2 : 3'd4, d});
		@(posedge clk_sys);
		cpuAddr <= a;
		cpuWrite <= wr;
		cpuWdata <= d;
		cpuReq <= 1'b1;
		@(posedge clk_sys);
		cpuReq <= 1'b0;
		#1;
		check(aleN === 1'b0 && busOut === a[11:4] && busOe === 8'hFF, "address phase");
		check(pfOut === expPf(a), "port F address");
		check(peOut === (rg == 0 ? 4'hF : ~(4'h1 << (rg - 1))), "select level");
		#(full ? 100 : 200);
		if (wr) begin
			check(wrN === 1'b0 && rdN === 1'b1 && busOut === d, "write phase");
		end else begin
			check(rdN === 1'b0 && wrN === 1'b1 && busOe === 8'h00, "read phase");
		end
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (cpuDone !== 1'b1 && n < 12);
		if (cpuDone !== 1'b1) timeOut();
	endtask

	task automatic runPass();
		for (int i = 0; i < 6; i++) begin
			rnd = nextRand();
			cpuCyc(ADDRS[i], 1'b1, rnd[7:0], RGS[i]);
			cpuCyc(ADDRS[i], 1'b0, rnd[7:0], RGS[i]);
		end
	endtask

	// ==========================================
	// watcher: each result takes the oldest note off its queue
	always @(posedge clk_sys) begin
		if (cpuBusy === 1'b1) busyCnt++;
		if (cpuDone === 1'b1) begin
			cpuE = cpuQ.pop_front();
			check(busyCnt == int'(cpuE[10:8]), "cycle length");
			if (cpuE[11]) check(cpuRdata === cpuE[7:0], "read data");
			busyCnt = 0;
		end
		if (bv === 1'b1 && bRdy) begin
			axiE = axiQ.pop_front();
			check(bResp === axiE[33:32], "write answer");
		end
		if (rv === 1'b1 && rRdy) begin
			axiE = axiQ.pop_front();
			check(rResp === axiE[33:32] && rData === axiE[31:0], "register read");
		end
	end

	// ==========================================
	// main sequence
	initial begin
		repeat (2) @(posedge clk_sys);
		#1;
		check(busOe === 8'h00 && pfOe === 8'h00 && peOe === 4'h0, "float in reset");
		check(rdN === 1'b1 && wrN === 1'b1, "strobes in reset");
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rnd = nextRand();
		gpF <= rnd[7:0];
		gpE <= rnd[11:8];
		axiRd(OFF_BUS_CONTROL, 8'h00, RESP_OKAY);
		check(pfOe === 8'hFF && peOe === 4'hF && busOe === 8'hFF, "pins driven after reset");
		axiRd(OFF_STATUS, 8'h00, RESP_OKAY);
		axiRd(OFF_CLEAR_INT, 8'h00, RESP_OKAY);
		axiRd(OFF_MASK_OPTION, MASK_EXP, RESP_OKAY);
		axiWr(OFF_MASK_OPTION, 8'hFF, RESP_SLVERR);
		axiRd(OFF_MASK_OPTION, MASK_EXP, RESP_OKAY);
		axiRd(8'h40, 8'h00, RESP_SLVERR);
		runPass();
		axiWr(OFF_BUS_CONTROL, 8'h0F, RESP_OKAY);
		bcrVal = 4'hF;
		axiWr(OFF_CLEAR_INT, 8'h04, RESP_OKAY);
		cirBit = 1'b1;
		axiRd(OFF_BUS_CONTROL, 8'h0F, RESP_OKAY);
		axiRd(OFF_CLEAR_INT, 8'h04, RESP_OKAY);
		runPass();
		axiWr(OFF_BUS_CONTROL, 8'h05, RESP_OKAY);
		bcrVal = 4'h5;
		axiWr(OFF_CLEAR_INT, 8'h00, RESP_OKAY);
		cirBit = 1'b0;
		runPass();
		endSim();
	end
endmodule // test_expansion_bus_chip_select
